/* File: sbc_commutator.sv */
`timescale 1ns/1ps
// How it works
// - each step drives two phases, one high and one low, the third floats.
// - steps run Z,L,H / H,L,Z / H,Z,L / Z,H,L / L,H,Z / L,Z,H then wrap.
// - only the floating phase's comparator is enabled and used.
// - a zero-crossing starts the adaptive delay; its end advances the step.
// - the open-collector tacho runs at half the commutation rate.
// - without zero-crossings the start oscillator issues step pulses.
// - every commutation restarts the start oscillator's period.
// - the start ramp rises then falls between its thresholds each period.
// - the delay accumulator charges all period, paused during flyback.
// - next period it discharges at twice the rate; floor ends the delay.
// - the delay accumulator is clamped between 0.9 and 2.2 V.
// - a second accumulator repeats the delay at equal 15.5 rates.
// - the timing ramp goes fast to 0.30, slow to 2.20, down at 28.
// - the slow ramp runs on wrong EMF polarity, and in blanking while flyback outlasts the fast ramp; top is a timeout.
// - the tacho inverts on each detected zero-crossing.
module sbc_commutator #(
  parameter int unsigned START_OSC_TIMER_NF = 220,
  parameter int unsigned STEP_WATCHDOG_TIMER_NF = 10,
  parameter int unsigned DELAY_ACCUMULATOR_NF = 18,
  parameter int unsigned DELAY_REPEAT_ACCUMULATOR_NF = 18
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic emfCmpA,
  input  wire logic emfCmpB,
  input  wire logic emfCmpC,
  input  wire logic flybackPulse,
  output logic      phaseOutA,
  output logic      phaseOeA,
  output logic      phaseOutB,
  output logic      phaseOeB,
  output logic      phaseOutC,
  output logic      phaseOeC,
  output logic      emfEnA,
  output logic      emfEnB,
  output logic      emfEnC,
  output logic      tachoOut,
  output logic      tachoOe,
  output logic      commPulse,
  output logic      watchdogTimeout
);
  import sbc_pkg::*;

  // step sizes per clock, nV
  localparam logic [31:0] ST_STEP =
    32'(ST_TENTH_UA * NV_PER_TENTH_UA_NF / START_OSC_TIMER_NF);
  localparam logic [31:0] TI_FAST =
    32'(TI_FAST_TENTH_UA * NV_PER_TENTH_UA_NF / STEP_WATCHDOG_TIMER_NF);
  localparam logic [31:0] TI_SLOW =
    32'(TI_SLOW_TENTH_UA * NV_PER_TENTH_UA_NF / STEP_WATCHDOG_TIMER_NF);
  localparam logic [31:0] TI_SINK =
    32'(TI_SINK_TENTH_UA * NV_PER_TENTH_UA_NF / STEP_WATCHDOG_TIMER_NF);
  localparam logic [31:0] CD_UP =
    32'(CD_UP_TENTH_UA * NV_PER_TENTH_UA_NF / DELAY_ACCUMULATOR_NF);
  localparam logic [31:0] CD_DN =
    32'(CD_DN_TENTH_UA * NV_PER_TENTH_UA_NF / DELAY_ACCUMULATOR_NF);
  localparam logic [31:0] DC_STEP =
    32'(DC_TENTH_UA * NV_PER_TENTH_UA_NF / DELAY_REPEAT_ACCUMULATOR_NF);

  sbc_step_t  step_ff;
  sbc_step_t  nxt_step;
  sbc_cycle_t cycle_ff;
  logic       parity_ff;
  logic       tacho_ff;
  logic       stRising_ff;
  logic [2:0] drvHigh;
  logic [2:0] drvOe;
  logic       expectPol;
  logic       selEmf;
  logic       emfRight;
  logic       zcEvent;
  logic       delayDone;
  logic       startPulse;
  logic [31:0] stLevel, tiLevel, cdLevel;
  logic       stFloor, stCeil, tiCeil, cdFloor, cdCeil;
  logic       dcFloor;
  logic       inDelay;

  ////////////////////////////////////////////////////////////////////
  // output stage decode
  always_comb begin
    drvHigh   = 3'h0;
    drvOe     = 3'h0;
    expectPol = 1'b0;
    case (step_ff)
      STEP1: begin drvOe = 3'h6; drvHigh = 3'h4; expectPol = 1'b1; end
      STEP2: begin drvOe = 3'h3; drvHigh = 3'h1; expectPol = 1'b0; end
      STEP3: begin drvOe = 3'h5; drvHigh = 3'h1; expectPol = 1'b1; end
      STEP4: begin drvOe = 3'h6; drvHigh = 3'h2; expectPol = 1'b0; end
      STEP5: begin drvOe = 3'h3; drvHigh = 3'h2; expectPol = 1'b1; end
      STEP6: begin drvOe = 3'h5; drvHigh = 3'h4; expectPol = 1'b0; end
      default: begin drvOe = 3'h0; drvHigh = 3'h0; expectPol = 1'b0; end
    endcase
  end

  // bit 0 is phase A, bit 2 phase C
  assign phaseOeA  = drvOe[0];
  assign phaseOeB  = drvOe[1];
  assign phaseOeC  = drvOe[2];
  assign phaseOutA = drvHigh[0];
  assign phaseOutB = drvHigh[1];
  assign phaseOutC = drvHigh[2];

  // the floating phase owns the comparator
  assign emfEnA = ~drvOe[0];
  assign emfEnB = ~drvOe[1];
  assign emfEnC = ~drvOe[2];
  assign selEmf = (emfEnA & emfCmpA) | (emfEnB & emfCmpB)
                | (emfEnC & emfCmpC);
  assign emfRight = (selEmf == expectPol);

  ////////////////////////////////////////////////////////////////////
  // step sequencer
  always_comb begin
    case (step_ff)
      STEP1:   nxt_step = STEP2;
      STEP2:   nxt_step = STEP3;
      STEP3:   nxt_step = STEP4;
      STEP4:   nxt_step = STEP5;
      STEP5:   nxt_step = STEP6;
      STEP6:   nxt_step = STEP1;
      default: nxt_step = STEP1;
    endcase
  end

  assign inDelay   = (cycle_ff == CY_DELAY);
  assign delayDone = inDelay && (parity_ff ? cdFloor : dcFloor);
  assign commPulse = delayDone | startPulse;

  always_ff @(posedge clock) begin
    if (rst) begin
      step_ff <= STEP1;
    end else if (commPulse) begin
      step_ff <= nxt_step;
    end
  end

  // delay roles swap every period
  always_ff @(posedge clock) begin
    if (rst) begin
      parity_ff <= PARITY_RESET;
    end else if (commPulse) begin
      parity_ff <= ~parity_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // period phases: blanking, watch for crossing, delay, idle
  assign zcEvent = (cycle_ff == CY_WATCH) && emfRight && !flybackPulse;
  assign watchdogTimeout = (cycle_ff == CY_WATCH) && !emfRight
                         && tiCeil;

  always_ff @(posedge clock) begin
    if (rst) begin
      cycle_ff <= CY_BLANK;
    end else if (commPulse) begin
      cycle_ff <= CY_BLANK;
    end else begin
      case (cycle_ff)
        CY_BLANK: begin
          // diode pulse must be gone before the crossing is trusted
          if (tiLevel >= TI_MID_NV && !flybackPulse) begin
            cycle_ff <= CY_WATCH;
          end
        end
        CY_WATCH: begin
          if (zcEvent) begin
            cycle_ff <= CY_DELAY;
          end else if (watchdogTimeout) begin
            cycle_ff <= CY_IDLE;
          end
        end
        CY_DELAY: cycle_ff <= CY_DELAY;
        CY_IDLE:  cycle_ff <= CY_IDLE;
        default:  cycle_ff <= CY_BLANK;
      endcase
    end
  end

  // open collector: pin pulled low while the level is low
  always_ff @(posedge clock) begin
    if (rst) begin
      tacho_ff <= TACHO_RESET;
    end else if (zcEvent) begin
      tacho_ff <= ~tacho_ff;
    end
  end
  assign tachoOut = 1'b0;
  assign tachoOe  = ~tacho_ff;

  ////////////////////////////////////////////////////////////////////
  // start oscillator
  always_ff @(posedge clock) begin
    if (rst) begin
      stRising_ff <= 1'b1;
    end else if (commPulse) begin
      stRising_ff <= 1'b1;
    end else if (stRising_ff && stCeil) begin
      stRising_ff <= 1'b0;
    end
  end
  // limitation: also fires after a watchdog timeout, which is intended
  assign startPulse = !stRising_ff && stFloor;

  sbc_ramp uStartOsc (
    .clock    (clock),
    .rst      (rst),
    .clear    (commPulse),
    .upEn     (stRising_ff),
    .dnEn     (!stRising_ff),
    .upStep   (ST_STEP),
    .dnStep   (ST_STEP),
    .floorVal (ST_LOW_NV),
    .ceilVal  (ST_HIGH_NV),
    .level    (stLevel),
    .atFloor  (stFloor),
    .atCeil   (stCeil)
  );

  sbc_ramp uStepWatchdog (
    .clock    (clock),
    .rst      (rst),
    .clear    (commPulse),
    .upEn     ((cycle_ff == CY_BLANK) ||
               ((cycle_ff == CY_WATCH) && !emfRight)),
    .dnEn     (inDelay || (cycle_ff == CY_IDLE)),
    .upStep   ((tiLevel < TI_MID_NV) ? TI_FAST : TI_SLOW),
    .dnStep   (TI_SINK),
    .floorVal (TI_LOW_NV),
    .ceilVal  (TI_HIGH_NV),
    .level    (tiLevel),
    .atFloor  (),
    .atCeil   (tiCeil)
  );

  sbc_ramp uDelayAcc (
    .clock    (clock),
    .rst      (rst),
    .clear    (1'b0),
    .upEn     (!parity_ff && !flybackPulse),
    .dnEn     (parity_ff && inDelay),
    .upStep   (CD_UP),
    .dnStep   (CD_DN),
    .floorVal (CD_LOW_NV),
    .ceilVal  (CD_HIGH_NV),
    .level    (cdLevel),
    .atFloor  (cdFloor),
    .atCeil   (cdCeil)
  );

  // learns the delay while the main one plays it, then replays it
  sbc_ramp uDelayRepeat (
    .clock    (clock),
    .rst      (rst),
    .clear    (1'b0),
    .upEn     (parity_ff && inDelay),
    .dnEn     (!parity_ff && inDelay),
    .upStep   (DC_STEP),
    .dnStep   (DC_STEP),
    .floorVal (CD_LOW_NV),
    .ceilVal  (CD_HIGH_NV),
    .level    (),
    .atFloor  (dcFloor),
    .atCeil   ()
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_two_driven;
    $countones({phaseOeA, phaseOeB, phaseOeC}) == 2;
  endproperty
  a_two_driven: assert property (p_two_driven)
    else $error("not exactly two phases driven");

  property p_one_high;
    $countones({phaseOutA & phaseOeA, phaseOutB & phaseOeB,
                phaseOutC & phaseOeC}) == 1;
  endproperty
  a_one_high: assert property (p_one_high)
    else $error("not exactly one phase sourcing");

  property p_step_order;
    commPulse |=> step_ff == (($past(step_ff) == STEP6) ? STEP1
                  : sbc_step_t'($past(step_ff) + 3'h1));
  endproperty
  a_step_order: assert property (p_step_order)
    else $error("step did not advance by one");

  property p_hold_step;
    !commPulse |=> $stable(step_ff);
  endproperty
  a_hold_step: assert property (p_hold_step)
    else $error("step moved without a pulse");

  property p_emf_select;
    {emfEnC, emfEnB, emfEnA} == ~{phaseOeC, phaseOeB, phaseOeA}
      && $onehot({emfEnA, emfEnB, emfEnC});
  endproperty
  a_emf_select: assert property (p_emf_select)
    else $error("comparator enable not on floating phase");

  property p_zc_delay;
    zcEvent && !commPulse |=> inDelay;
  endproperty
  a_zc_delay: assert property (p_zc_delay)
    else $error("crossing did not start the delay");

  property p_tacho;
    zcEvent |=> tachoOe != $past(tachoOe);
  endproperty
  a_tacho: assert property (p_tacho)
    else $error("tacho did not toggle on crossing");

  property p_tacho_hold;
    !zcEvent |=> $stable(tachoOe) && !tachoOut;
  endproperty
  a_tacho_hold: assert property (p_tacho_hold)
    else $error("tacho moved without a crossing");

  property p_start_restart;
    commPulse |=> stRising_ff && stLevel == ST_LOW_NV;
  endproperty
  a_start_restart: assert property (p_start_restart)
    else $error("start oscillator not restarted");

  property p_start_step;
    startPulse |=> $past(step_ff) != step_ff;
  endproperty
  a_start_step: assert property (p_start_step)
    else $error("start pulse did not step outputs");

  property p_flyback_pause;
    !parity_ff && flybackPulse |=> $stable(cdLevel);
  endproperty
  a_flyback_pause: assert property (p_flyback_pause)
    else $error("delay accumulator charged during flyback");

  property p_cd_range;
    cdLevel >= CD_LOW_NV && cdLevel <= CD_HIGH_NV;
  endproperty
  a_cd_range: assert property (p_cd_range)
    else $error("delay accumulator out of range");

  property p_timeout;
    watchdogTimeout && !commPulse |=> cycle_ff == CY_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not stop the watch");

  c_crossing: cover property (zcEvent ##[1:1000] delayDone);
  c_timeout:  cover property (watchdogTimeout);
  c_start:    cover property (startPulse);
  c_saturate: cover property (cdCeil);
endmodule // sbc_commutator

/* File: sbc_commutator_tb_top.sv */
`timescale 1ns/1ps
module sbc_commutator_tb_top;
  import sbc_pkg::*;
  localparam int         FLY       = 20;
  localparam logic [2:0] OE_T  [6] = '{3'h3, 3'h6, 3'h5, 3'h3, 3'h6, 3'h5};
  localparam logic [2:0] OUT_T [6] = '{3'h1, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1};
  localparam logic [2:0] EN_T  [6] = '{3'h4, 3'h1, 3'h2, 3'h4, 3'h1, 3'h2};

  logic clock;
  logic rst;
  logic reverse;
  wire  emfCmpA;
  wire  emfCmpB;
  wire  emfCmpC;
  wire  flybackPulse;
  logic phaseOutA, phaseOeA, phaseOutB, phaseOeB, phaseOutC, phaseOeC;
  logic emfEnA, emfEnB, emfEnC, tachoOut, tachoOe;
  logic commPulse, watchdogTimeout;
  int   n_fail = 0;
  int   num_checks = 0;
  int   cyc = 0;

  // small capacitors keep the start period near 54k cycles
  sbc_commutator #(
    .START_OSC_TIMER_NF(1), .STEP_WATCHDOG_TIMER_NF(1), .DELAY_ACCUMULATOR_NF(1), .DELAY_REPEAT_ACCUMULATOR_NF(1)
  ) sbc_commutator_i (
    .clock(clock), .rst(rst), .emfCmpA(emfCmpA), .emfCmpB(emfCmpB),
    .emfCmpC(emfCmpC), .flybackPulse(flybackPulse),
    .phaseOutA(phaseOutA), .phaseOeA(phaseOeA), .phaseOutB(phaseOutB),
    .phaseOeB(phaseOeB), .phaseOutC(phaseOutC), .phaseOeC(phaseOeC),
    .emfEnA(emfEnA), .emfEnB(emfEnB), .emfEnC(emfEnC),
    .tachoOut(tachoOut), .tachoOe(tachoOe), .commPulse(commPulse),
    .watchdogTimeout(watchdogTimeout)
  );

  sbc_motor_model #(.EMF_DLY(1000), .FLY_LEN(FLY)) sbc_motor_model_i (
    .clock(clock), .reverse(reverse),
    .outAbc({phaseOutA, phaseOutB, phaseOutC}),
    .oeAbc({phaseOeA, phaseOeB, phaseOeC}),
    .cmpAbc({emfCmpA, emfCmpB, emfCmpC}), .flybackPulse(flybackPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_step(input int k);
    logic [2:0] oe;
    oe = {phaseOeA, phaseOeB, phaseOeC};
    check(32'(oe), 32'(OE_T[k]));
    check(32'({phaseOutA, phaseOutB, phaseOutC} & oe), 32'(OUT_T[k]));
    check(32'({emfEnA, emfEnB, emfEnC}), 32'(EN_T[k]));
    check(32'(tachoOut), 32'h0);
  endtask

  // counts from one commutation to the next, noting tacho and watchdog
  task automatic wait_comm(input int lim, output int n, output int tog,
                           output int tl, output int wd);
    logic t0;
    n = 0;
    tog = 0;
    tl = 0;
    wd = 0;
    t0 = tachoOe;
    do begin
      @(negedge clock);
      n++;
      if (tachoOe !== t0) begin
        tog++;
        tl = n;
        t0 = tachoOe;
      end
      if (watchdogTimeout === 1'b1) begin
        wd = n;
      end
    end while (commPulse !== 1'b1 && n < lim);
    check(32'(commPulse), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_step(0);
    check(32'(tachoOe), 32'h1);
  endtask

  // steady running: delay settles to half the previous charge time
  task automatic t_emf_run();
    int n, tog, tl, wd, pPrev, d;
    pPrev = 0;
    for (int i = 1; i <= 18; i++) begin
      wait_comm(6000, n, tog, tl, wd);
      check(32'(tog), 32'h1);
      d = n - tl;
      if (i >= 14) begin
        check(32'(d inside {[(pPrev - FLY) / 2 - 6 : (pPrev - FLY) / 2 + 6]}),
              32'h1);
      end
      pPrev = n;
      @(posedge clock);
      #1;
      check_step(i % 6);
    end
  endtask

  // wrong EMF: watchdog fires, then only the start oscillator advances
  task automatic t_reverse();
    int n, tog, tl, wd;
    reverse = 1'b1;
    wait_comm(60000, n, tog, tl, wd);
    check(32'(tog), 32'h0);
    check(32'(wd inside {[9600:9625]}), 32'h1);
    check(32'(n inside {[53745:53755]}), 32'h1);
    @(posedge clock);
    #1;
    check_step(19 % 6);
  endtask

  // the long start period saturates the accumulator: maximum delay follows
  task automatic t_slow_restart();
    int n, tog, tl, wd, mx;
    mx = (int'(CD_HIGH_NV - CD_LOW_NV) + CD_DN_TENTH_UA * NV_PER_TENTH_UA_NF
          - 1) / (CD_DN_TENTH_UA * NV_PER_TENTH_UA_NF);
    reverse = 1'b0;
    wait_comm(6000, n, tog, tl, wd);
    check(32'(tog), 32'h1);
    check(32'(wd), 32'h0);
    check(32'(n - tl), 32'(mx));
    @(posedge clock);
    #1;
    check_step(20 % 6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc >= 100000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    reverse = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_emf_run();
    t_reverse();
    t_slow_restart();
    end_sim();
  end
endmodule // sbc_commutator_tb_top

/* File: sbc_motor_model.sv */
`timescale 1ns/1ps
module sbc_motor_model #(
  parameter int EMF_DLY = 1000,
  parameter int FLY_LEN = 20
) (
  input  wire logic       clock,
  input  wire logic       reverse,
  input  wire logic [2:0] outAbc,
  input  wire logic [2:0] oeAbc,
  output logic      [2:0] cmpAbc,
  output logic            flybackPulse
);
  logic [2:0] oePrev = 3'h0;
  logic [2:0] v;
  logic       tgl    = 1'b0;
  logic       expPol;
  int         cnt    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // level the floating winding settles to once past its crossing
  always_comb begin
    case (oeAbc)
      3'h3:    expPol = outAbc[0];
      3'h5:    expPol = outAbc[2];
      default: expPol = outAbc[1];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // reverse rotation keeps the floating EMF on the wrong side
  always @(posedge clock) begin
    #1;
    tgl = ~tgl;
    cnt = (oeAbc != oePrev) ? 0 : cnt + 1;
    oePrev = oeAbc;
    flybackPulse = cnt < FLY_LEN;
    // driven windings give no settled level, so show a moving pattern
    v = {tgl, ~tgl, tgl};
    for (int i = 0; i < 3; i++) begin
      if (!oeAbc[i]) begin
        v[i] = (cnt >= EMF_DLY && !reverse) ? expPol : ~expPol;
      end
    end
    cmpAbc = v;
  end
endmodule // sbc_motor_model

/* File: sbc_pkg.sv */
package sbc_pkg;
  // timing and scaling
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  // nV gained per clock by 0.1 uA into 1 nF
  localparam int unsigned NV_PER_TENTH_UA_NF = 100 * CLK_PERIOD_NS;

  // start oscillator period, seconds per microfarad
  localparam real START_PERIOD_S_PER_UF = 2.15;

  // ramp currents in tenths of a microampere
  localparam int unsigned ST_TENTH_UA      = 20;
  localparam int unsigned TI_FAST_TENTH_UA = 570;
  localparam int unsigned TI_SLOW_TENTH_UA = 50;
  localparam int unsigned TI_SINK_TENTH_UA = 280;
  localparam int unsigned CD_UP_TENTH_UA   = 81;
  localparam int unsigned CD_DN_TENTH_UA   = 162;
  localparam int unsigned DC_TENTH_UA      = 155;

  // thresholds in nanovolts
  localparam logic [31:0] ST_LOW_NV  = 32'h02FA_F080; // 0.05 V
  localparam logic [31:0] ST_HIGH_NV = 32'h8321_5600; // 2.2 V
  localparam logic [31:0] TI_LOW_NV  = 32'h02FA_F080; // 0.05 V
  localparam logic [31:0] TI_MID_NV  = 32'h11E1_A300; // 0.30 V
  localparam logic [31:0] TI_HIGH_NV = 32'h8321_5600; // 2.20 V
  localparam logic [31:0] CD_LOW_NV  = 32'h35A4_E900; // 0.9 V
  localparam logic [31:0] CD_HIGH_NV = 32'h8321_5600; // 2.2 V

  // reset values
  localparam logic       TACHO_RESET  = 1'b0;
  localparam logic       PARITY_RESET = 1'b0;

  typedef enum logic [2:0] {
    STEP1, STEP2, STEP3, STEP4, STEP5, STEP6
  } sbc_step_t;

  typedef enum logic [1:0] {
    CY_BLANK, CY_WATCH, CY_DELAY, CY_IDLE
  } sbc_cycle_t;
endpackage

/* File: sbc_ramp.sv */
`timescale 1ns/1ps
module sbc_ramp (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        upEn,
  input  wire logic        dnEn,
  input  wire logic [31:0] upStep,
  input  wire logic [31:0] dnStep,
  input  wire logic [31:0] floorVal,
  input  wire logic [31:0] ceilVal,
  output logic      [31:0] level,
  output logic             atFloor,
  output logic             atCeil
);
  logic [31:0] level_ff;
  logic [32:0] upSum;
  logic [32:0] dnSum;
  logic [31:0] nxt_level;

  assign upSum = {1'b0, level_ff} + {1'b0, upStep};
  assign dnSum = {1'b0, level_ff} - {1'b0, dnStep};

  // saturating at both ends, like a capacitor clamped by its comparators
  always_comb begin
    nxt_level = level_ff;
    if (clear) begin
      nxt_level = floorVal;
    end else if (upEn) begin
      nxt_level = (upSum >= {1'b0, ceilVal}) ? ceilVal : upSum[31:0];
    end else if (dnEn) begin
      nxt_level = (dnSum[32] || dnSum[31:0] <= floorVal) ? floorVal
                                                          : dnSum[31:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // start on the clamp floor so the level is in range from reset on
      level_ff <= floorVal;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign level   = level_ff;
  assign atFloor = (level_ff <= floorVal);
  assign atCeil  = (level_ff >= ceilVal);
endmodule // sbc_ramp
